// ==== include/sfm_pkg.sv ====
// Overview of operation
// - timeout or enabled supply fail: fail-safe until exit word
// - grounded select disables watchdog, open select enables it
// - fail-safe: outputs follow inputs, config default, normal flag low
// - exit word with input bit high, supply good; clears latches
// - watchdog fail-safe also left by grounding select
// - normal left only on fail; entry clears latches
// - listed faults drive status pin low while wake pin high
// - pin self-recovers except latched current, short, heat, undervoltage
// - flags held until first valid transfer clears them
// - on-state open load sets only its flag
// - wake rise starts normal, registers cleared, full function later
// - overheat while on latches channel off, pin low
// - overheat while off holds pin low while hot; flag read-cleared
// - eight-level current profile, lamp type, selectable steady limit
// - inrush restarts on release rise or retry; slope, skip bit
// - current level reached latches off, pin low; flag read-cleared
// - cool emulation makes first step depend on off time
// - severe short latches off, pin low; toggle release only
// - overvoltage forces outputs off, pin low until below hysteresis
// - protection disabled: overvoltage still flagged as warning
// - fail-safe overvoltage protection follows wake pin
// - fail from enabled supply failure or timeout with select open
// - release control: direct input path or on bit
package sfm_pkg;
  localparam int unsigned NCH          = 4;
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned STARTUP_US   = 50;
  localparam int unsigned STARTUP_CYC  = (STARTUP_US * (CLK_HZ / 1_000_000));
  localparam int unsigned WDOG_CYC_DEF = 32'd1_000_000;
  localparam int unsigned STEP_CYC     = 32'd10_000;
  localparam logic [1:0]  STEADY_DEF   = 2'h1;
  localparam logic [1:0]  INRUSH_DEF   = 2'h0;
  localparam logic [2:0]  LAST_STEP    = 3'h7;
  typedef enum logic [1:0] {SFM_SLEEP, SFM_START, SFM_NORMAL, SFM_FAILSAFE} sfm_mode_t;
endpackage : sfm_pkg

// ==== logic/sfm_channel.sv ====
`timescale 1ns/1ns
module sfm_channel
  import sfm_pkg::*;
(
  input  wire logic       core_clk_in,
  input  wire logic       nrst_in,
  input  wire logic       clear_in,
  input  wire logic       active_in,
  input  wire logic       ctrl_in,
  input  wire logic       cmd_in,
  input  wire logic       ot_in,
  input  wire logic       oc_level_in,
  input  wire logic       short_in,
  input  wire logic       uv_in,
  input  wire logic       retry_in,
  input  wire logic       small_lamp_in,
  input  wire logic [1:0] inrush_slope_in,
  input  wire logic       skip_in,
  input  wire logic       cool_en_in,
  input  wire logic [1:0] cool_slope_in,
  input  wire logic [1:0] steady_in,
  output logic      [2:0] level_out,
  output logic            latched_out,
  output logic            enable_out
);
  logic        ctrl_r;
  logic        ot_lat_r;
  logic        oc_lat_r;
  logic        sc_lat_r;
  logic        uv_lat_r;
  logic [2:0]  step_r;
  logic [15:0] cnt_r;
  logic [15:0] off_r;
  logic [2:0]  level_r;

  // ------------
  // release detection and profile restart
  // ------------
  wire toggle    = ctrl_in & ~ctrl_r;
  wire restart   = toggle | retry_in;
  wire [2:0] first_step = skip_in ? 3'h1 : 3'h0;
  // long off time lets the filament cool, so start from the first step again; a short one starts at step 3
  wire cool_warm = cool_en_in && (off_r < {cool_slope_in, 14'h0});
  wire [2:0] start_step = cool_warm ? 3'h3 : first_step;
  wire [15:0] step_len = STEP_CYC[15:0] >> inrush_slope_in;
  wire [2:0] steady_lvl = {1'b1, steady_in} + 3'h0;
  wire [2:0] prof_lvl = (step_r == LAST_STEP) ? steady_lvl
                      : (small_lamp_in ? (step_r | 3'h1) : step_r);

  wire ot_trip = ot_in & cmd_in;
  wire oc_trip = oc_level_in & cmd_in;
  wire uv_trip = uv_in & cmd_in;

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl_r   <= 1'b0;
      ot_lat_r <= 1'b0;
      oc_lat_r <= 1'b0;
      sc_lat_r <= 1'b0;
      uv_lat_r <= 1'b0;
    end else begin
      ctrl_r   <= ctrl_in;
      // trip wins over clear; release needs the condition gone
      ot_lat_r <= active_in & (ot_trip | (ot_lat_r & ~clear_in & ~(restart & ~ot_in)));
      oc_lat_r <= active_in & (oc_trip | (oc_lat_r & ~clear_in & ~(restart & ~oc_level_in)));
      sc_lat_r <= active_in & (short_in | (sc_lat_r & ~clear_in & ~(toggle & ~short_in)));
      uv_lat_r <= active_in & (uv_trip | (uv_lat_r & ~clear_in & ~(restart & ~uv_in)));
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      step_r  <= 3'h0;
      cnt_r   <= 16'h0;
      off_r   <= 16'h0;
      level_r <= 3'h0;
    end else begin
      off_r   <= ctrl_in ? 16'h0 : ((off_r == 16'hffff) ? off_r : off_r + 16'h1);
      level_r <= prof_lvl;
      if (restart) begin
        step_r <= start_step;
        cnt_r  <= 16'h0;
      end else if (step_r != LAST_STEP) begin
        if (cnt_r >= step_len) begin
          step_r <= step_r + 3'h1;
          cnt_r  <= 16'h0;
        end else begin
          cnt_r <= cnt_r + 16'h1;
        end
      end
    end
  end

  assign latched_out = ot_lat_r | oc_lat_r | sc_lat_r | uv_lat_r;
  assign enable_out  = cmd_in & ~latched_out;
  assign level_out   = level_r;
endmodule : sfm_channel

// ==== logic/sfm_controller.sv ====
`timescale 1ns/1ns
module sfm_controller
  import sfm_pkg::*;
#(
  parameter int unsigned WDOG_CYC = WDOG_CYC_DEF
)(
  input  wire logic             core_clk_in,
  input  wire logic             nrst_in,
  input  wire logic             wake_reset_in,
  input  wire logic             failsafe_select_input_in,
  input  wire logic             vdd_fail_in,
  input  wire logic             vdd_fail_en_in,
  input  wire logic             spi_word_valid_in,
  input  wire logic             watchdog_refresh_bit_in,
  input  wire logic             watchdog_input_bit_in,
  input  wire logic             spi_read_in,
  input  wire logic [NCH-1:0]   direct_in,
  input  wire logic [NCH-1:0]   direct_dis_in,
  input  wire logic [NCH-1:0]   on_bit_in,
  input  wire logic             pwm_en_in,
  input  wire logic             pwm_internal_in,
  input  wire logic [NCH-1:0]   pwm_duty_in,
  input  wire logic [NCH-1:0]   overtemp_in,
  input  wire logic [NCH-1:0]   overcurrent_in,
  input  wire logic [NCH-1:0]   severe_short_in,
  input  wire logic [NCH-1:0]   short_supply_off_in,
  input  wire logic [NCH-1:0]   open_load_off_in,
  input  wire logic [NCH-1:0]   open_load_on_in,
  input  wire logic             overvoltage_in,
  input  wire logic             undervoltage_in,
  input  wire logic [NCH-1:0]   retry_in,
  input  wire logic             overvoltage_protect_disable_in,
  input  wire logic [NCH-1:0]   small_lamp_profile_bit_in,
  input  wire logic [NCH-1:0]   discharge_lamp_bit_in,
  input  wire logic [1:0]       inrush_slope_field_in,
  input  wire logic             inrush_step_skip_bit_in,
  input  wire logic             cool_emulation_enable_in,
  input  wire logic [1:0]       cool_slope_field_in,
  input  wire logic [1:0]       steady_limit_select_in,
  output logic [NCH-1:0]        hs_out,
  output logic [3*NCH-1:0]      oc_level_out,
  output logic                  fault_status_pin_n_out,
  output logic                  normal_mode_flag_out,
  output logic                  full_function_out,
  output logic                  config_default_out,
  output logic [NCH-1:0]        overtemp_flags_out,
  output logic [NCH-1:0]        overcurrent_flags_out,
  output logic [NCH-1:0]        severe_short_flags_out,
  output logic [NCH-1:0]        short_supply_flags_out,
  output logic [NCH-1:0]        open_load_off_flags_out,
  output logic [NCH-1:0]        open_load_on_flags_out,
  output logic                  overvoltage_flag_out,
  output logic                  undervoltage_flag_out
);
  sfm_mode_t   mode_r;
  sfm_mode_t   mode_nxt;
  logic        wake_r;
  logic        fs_wd_r;
  logic [31:0] wd_cnt_r;
  logic        wd_prev_r;
  logic [31:0] st_cnt_r;
  logic [NCH-1:0] ot_f_r;
  logic [NCH-1:0] oc_f_r;
  logic [NCH-1:0] sc_f_r;
  logic [NCH-1:0] os_f_r;
  logic [NCH-1:0] olf_f_r;
  logic [NCH-1:0] oln_f_r;
  logic        ov_f_r;
  logic        uv_f_r;
  logic        ov_lock_r;
  logic [NCH-1:0] latched;
  logic [NCH-1:0] ch_en;

  // ------------
  // mode decode
  // ------------
  wire wake_rise   = wake_reset_in & ~wake_r;
  wire wd_enabled  = failsafe_select_input_in;
  wire wd_timeout  = wd_enabled && (wd_cnt_r >= WDOG_CYC);
  wire vdd_fail    = vdd_fail_in & vdd_fail_en_in;
  wire fail        = vdd_fail | wd_timeout;
  wire exit_word   = spi_word_valid_in & watchdog_input_bit_in & ~vdd_fail_in;
  wire exit_select = fs_wd_r & ~failsafe_select_input_in & ~vdd_fail;
  wire in_fs       = (mode_r == SFM_FAILSAFE);
  wire active      = (mode_r == SFM_NORMAL) | (mode_r == SFM_START) | in_fs;
  wire enter_fs    = ~in_fs & active & fail;
  wire leave_fs    = in_fs & (exit_word | exit_select);
  wire clear_lat   = enter_fs | leave_fs | ~active;
  wire cfg_default = in_fs | ~active;

  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      SFM_SLEEP:    if (wake_rise) mode_nxt = SFM_START;
      SFM_START:    if (fail) mode_nxt = SFM_FAILSAFE;
                    else if (st_cnt_r >= STARTUP_CYC) mode_nxt = SFM_NORMAL;
      SFM_NORMAL:   if (fail) mode_nxt = SFM_FAILSAFE;
      SFM_FAILSAFE: if (leave_fs) mode_nxt = SFM_NORMAL;
      default:      mode_nxt = SFM_SLEEP;
    endcase
  end

  // ------------
  // mode and watchdog
  // ------------
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mode_r    <= SFM_SLEEP;
      wake_r    <= 1'b0;
      fs_wd_r   <= 1'b0;
      wd_prev_r <= 1'b0;
      wd_cnt_r  <= 32'h0;
      st_cnt_r  <= 32'h0;
    end else begin
      mode_r    <= mode_nxt;
      wake_r    <= wake_reset_in;
      if (enter_fs) fs_wd_r <= wd_timeout & ~vdd_fail;
      else if (leave_fs) fs_wd_r <= 1'b0;
      if (spi_word_valid_in) wd_prev_r <= watchdog_refresh_bit_in;
      // refresh toggle restarts the timeout; fail-safe holds it cleared at zero
      if (!active || in_fs || !wd_enabled || wake_rise) wd_cnt_r <= 32'h0;
      else if (spi_word_valid_in && (watchdog_refresh_bit_in != wd_prev_r)) wd_cnt_r <= 32'h0;
      else if (!wd_timeout) wd_cnt_r <= wd_cnt_r + 32'h1;
      st_cnt_r <= (mode_r == SFM_START) ? st_cnt_r + 32'h1 : 32'h0;
    end
  end

  // ------------
  // per-channel command and protection
  // ------------
  wire [NCH-1:0] on_eff    = cfg_default ? {NCH{1'b0}} : on_bit_in;
  wire [NCH-1:0] dis_eff   = cfg_default ? {NCH{1'b0}} : direct_dis_in;
  wire           pwm_eff   = pwm_en_in & ~cfg_default;
  wire [NCH-1:0] fctrl     = ((direct_in & ~dis_eff) & {NCH{~pwm_eff}}) | on_eff;
  wire [NCH-1:0] cmd       = in_fs ? direct_in
                           : ((((direct_in & ~dis_eff) | on_eff) & {NCH{~pwm_eff}})
                           | (on_eff & pwm_duty_in & {NCH{pwm_eff}}));
  wire ov_protect = in_fs ? wake_reset_in : ~overvoltage_protect_disable_in;
  wire ov_off     = ov_protect & ov_lock_r;
  wire [1:0] steady_eff = cfg_default ? STEADY_DEF : steady_limit_select_in;
  wire [1:0] inrush_eff = cfg_default ? INRUSH_DEF : inrush_slope_field_in;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      sfm_channel u_ch (
        .core_clk_in     (core_clk_in),
        .nrst_in         (nrst_in),
        .clear_in        (clear_lat),
        .active_in       (active),
        .ctrl_in         (fctrl[g]),
        .cmd_in          (cmd[g]),
        .ot_in           (overtemp_in[g]),
        .oc_level_in     (overcurrent_in[g]),
        .short_in        (severe_short_in[g]),
        .uv_in           (undervoltage_in),
        .retry_in        (retry_in[g]),
        .small_lamp_in   (small_lamp_profile_bit_in[g] & ~cfg_default),
        .inrush_slope_in (inrush_eff),
        .skip_in         (inrush_step_skip_bit_in & ~cfg_default),
        .cool_en_in      (cool_emulation_enable_in & discharge_lamp_bit_in[g]
                          & pwm_internal_in & pwm_eff & (mode_r == SFM_NORMAL)),
        .cool_slope_in   (cfg_default ? 2'h0 : cool_slope_field_in),
        .steady_in       (steady_eff),
        .level_out       (oc_level_out[3*g +: 3]),
        .latched_out     (latched[g]),
        .enable_out      (ch_en[g])
      );
    end
  endgenerate

  // ------------
  // fault flags and status pin
  // ------------
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ot_f_r    <= '0;
      oc_f_r    <= '0;
      sc_f_r    <= '0;
      os_f_r    <= '0;
      olf_f_r   <= '0;
      oln_f_r   <= '0;
      ov_f_r    <= 1'b0;
      uv_f_r    <= 1'b0;
      ov_lock_r <= 1'b0;
    end else begin
      // a new event in the read cycle survives the read
      ot_f_r  <= overtemp_in | (ot_f_r & ~{NCH{spi_read_in}});
      oc_f_r  <= overcurrent_in | (oc_f_r & ~{NCH{spi_read_in}});
      sc_f_r  <= severe_short_in | (sc_f_r & ~{NCH{spi_read_in}});
      os_f_r  <= (short_supply_off_in & ~cmd) | (os_f_r & ~{NCH{spi_read_in}});
      olf_f_r <= (open_load_off_in & ~cmd) | (olf_f_r & ~{NCH{spi_read_in}});
      oln_f_r <= (open_load_on_in & cmd) | (oln_f_r & ~{NCH{spi_read_in}});
      ov_f_r  <= overvoltage_in | (ov_f_r & ~spi_read_in);
      uv_f_r  <= wake_rise | undervoltage_in | (uv_f_r & ~spi_read_in);
      // hysteresis: the comparator input drops only below threshold minus hysteresis
      ov_lock_r <= overvoltage_in;
    end
  end

  wire [NCH-1:0] ot_off = overtemp_in & ~cmd;
  wire any_fault = (|latched) | (|ot_off) | (|(short_supply_off_in & ~cmd))
                 | (|(open_load_off_in & ~cmd)) | ov_off | undervoltage_in;

  assign fault_status_pin_n_out  = ~(wake_reset_in & active & any_fault);
  assign hs_out                  = ch_en & {NCH{~ov_off & active}};
  assign normal_mode_flag_out    = active & ~in_fs;
  assign full_function_out       = (mode_r == SFM_NORMAL);
  assign config_default_out      = cfg_default;
  assign overtemp_flags_out      = ot_f_r;
  assign overcurrent_flags_out   = oc_f_r;
  assign severe_short_flags_out  = sc_f_r;
  assign short_supply_flags_out  = os_f_r;
  assign open_load_off_flags_out = olf_f_r;
  assign open_load_on_flags_out  = oln_f_r;
  assign overvoltage_flag_out    = ov_f_r;
  assign undervoltage_flag_out   = uv_f_r;
endmodule : sfm_controller

// ==== sim/sfm_checker.sv ====
`timescale 1ns/1ns
module sfm_checker
  import sfm_pkg::*;
#(
  parameter int unsigned WDOG_CYC = WDOG_CYC_DEF
)(
  input wire logic           core_clk_in,
  input wire logic           nrst_in,
  input wire logic           wake_reset_in,
  input wire logic           failsafe_select_input_in,
  input wire logic           vdd_fail_in,
  input wire logic           vdd_fail_en_in,
  input wire logic           spi_read_in,
  input wire logic           overvoltage_in,
  input wire logic           undervoltage_in,
  input wire logic           overvoltage_protect_disable_in,
  input wire logic [NCH-1:0] direct_in,
  input wire logic [NCH-1:0] on_bit_in,
  input wire logic [NCH-1:0] overtemp_in,
  input wire logic [NCH-1:0] overcurrent_in,
  input wire logic [NCH-1:0] severe_short_in,
  input wire logic [NCH-1:0] hs_out,
  input wire logic           fault_status_pin_n_out,
  input wire logic           normal_mode_flag_out,
  input wire logic           full_function_out,
  input wire logic           config_default_out,
  input wire logic           undervoltage_flag_out,
  input wire logic [NCH-1:0] overcurrent_flags_out,
  input wire logic [NCH-1:0] severe_short_flags_out
);
  // ------------
  // mode tracking
  // ------------
  // sleep is never re-entered, so once normal was seen a low flag means fail-safe
  logic        was_normal_r;
  logic        seen_ff_r;
  int unsigned st_cnt_r;
  wire         in_fs   = was_normal_r && !normal_mode_flag_out;
  wire         quiet   = !overvoltage_in && !undervoltage_in
                         && (overtemp_in | overcurrent_in | severe_short_in) == '0;
  wire         ov_act  = overvoltage_in && !overvoltage_protect_disable_in
                         && normal_mode_flag_out && wake_reset_in;
  wire         sup_bad = vdd_fail_in && vdd_fail_en_in;
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      was_normal_r <= 1'b0;
      seen_ff_r    <= 1'b0;
      st_cnt_r     <= 0;
    end else begin
      was_normal_r <= was_normal_r | normal_mode_flag_out;
      seen_ff_r    <= seen_ff_r | full_function_out;
      st_cnt_r     <= st_cnt_r + 32'(normal_mode_flag_out && !full_function_out);
    end
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_ov_held;
    ov_act ##1 ov_act;
  endsequence
  chk_ovp_all_off: assert property (s_ov_held |-> hs_out == '0 && !fault_status_pin_n_out)
    else $error("ov not enforced");
  chk_wake_start: assert property ($rose(wake_reset_in) && !was_normal_r |=> normal_mode_flag_out && undervoltage_flag_out)
    else $error("bad wake start");
  chk_start_bound: assert property (normal_mode_flag_out && !full_function_out && !seen_ff_r |-> st_cnt_r <= STARTUP_CYC)
    else $error("start too long");
  chk_start_exact: assert property ($rose(full_function_out) && !seen_ff_r |-> st_cnt_r == STARTUP_CYC + 1)
    else $error("start length");
  chk_supply_fail: assert property (normal_mode_flag_out && sup_bad |=> !normal_mode_flag_out)
    else $error("no fail entry");
  chk_exit_refused: assert property (in_fs && sup_bad |=> !normal_mode_flag_out)
    else $error("exit not refused");
  chk_wdog_grounded: assert property (normal_mode_flag_out && !failsafe_select_input_in && !sup_bad && wake_reset_in |=> normal_mode_flag_out)
    else $error("left normal");
  chk_fs_follow: assert property (in_fs && quiet |-> hs_out == direct_in)
    else $error("no input follow");
  chk_fs_defaults: assert property (in_fs |-> config_default_out && !full_function_out)
    else $error("no defaults");
  chk_read_clear: assert property (spi_read_in && $past(overcurrent_in | severe_short_in) == '0 && (overcurrent_in | severe_short_in) == '0 |=> (overcurrent_flags_out | severe_short_flags_out) == '0)
    else $error("flag kept");
  chk_short_hold: assert property (normal_mode_flag_out && $fell(severe_short_in[1]) && $stable(on_bit_in) && $stable(direct_in) |-> !hs_out[1])
    else $error("short released");
endmodule : sfm_checker

bind sfm_controller sfm_checker #(.WDOG_CYC(WDOG_CYC)) u_sfm_chk (.*);

// ==== sim/sfm_host_model.sv ====
`timescale 1ns/1ns
module sfm_host_model (
  input  wire logic core_clk_in,
  input  wire logic refresh_en_in,
  output logic      spi_word_valid_out,
  output logic      watchdog_refresh_bit_out,
  output logic      watchdog_input_bit_out
);
  // ------------
  // word scheduler
  // ------------
  logic [4:0] gap_r;
  logic       exit_req;
  initial begin
    {spi_word_valid_out, watchdog_refresh_bit_out, watchdog_input_bit_out, exit_req} = '0;
    gap_r = 5'h0;
  end
  task automatic send_exit;
    exit_req = 1'b1;
  endtask : send_exit
  always @(negedge core_clk_in) begin
    spi_word_valid_out     <= 1'b0;
    // data bit is junk between words, so the device must not look at it then
    watchdog_input_bit_out <= ~watchdog_input_bit_out;
    gap_r                  <= gap_r + 5'h1;
    if (exit_req) begin
      spi_word_valid_out     <= 1'b1;
      watchdog_input_bit_out <= 1'b1;
      exit_req               <= 1'b0;
    end else if (refresh_en_in && gap_r >= 5'h14) begin
      spi_word_valid_out       <= 1'b1;
      watchdog_refresh_bit_out <= ~watchdog_refresh_bit_out;
      watchdog_input_bit_out   <= 1'b0;
      gap_r                    <= 5'h0;
    end
  end
endmodule : sfm_host_model

// ==== sim/tb_switch_fault_mode_controller.sv ====
`timescale 1ns/1ns
module tb_switch_fault_mode_controller
  import sfm_pkg::*;
();
  // ------------
  // stimulus and observation
  // ------------
  logic core_clk_in = 1'b0;
  logic nrst_in, wake_reset_in, failsafe_select_input_in, vdd_fail_in, vdd_fail_en_in;
  logic spi_read_in, pwm_en_in, pwm_internal_in, overvoltage_in, undervoltage_in, refresh_en;
  logic overvoltage_protect_disable_in, inrush_step_skip_bit_in, cool_emulation_enable_in;
  logic spi_word_valid_in, watchdog_refresh_bit_in, watchdog_input_bit_in;
  logic [1:0] inrush_slope_field_in, cool_slope_field_in, steady_limit_select_in;
  logic [NCH-1:0] direct_in, direct_dis_in, on_bit_in, pwm_duty_in, overtemp_in, retry_in;
  logic [NCH-1:0] overcurrent_in, severe_short_in, short_supply_off_in, open_load_off_in;
  logic [NCH-1:0] open_load_on_in, small_lamp_profile_bit_in, discharge_lamp_bit_in, hs_out;
  logic [NCH-1:0] overtemp_flags_out, overcurrent_flags_out, severe_short_flags_out;
  logic [NCH-1:0] open_load_on_flags_out, short_supply_flags_out, open_load_off_flags_out;
  logic fault_status_pin_n_out, normal_mode_flag_out, full_function_out, config_default_out;
  logic overvoltage_flag_out, undervoltage_flag_out;
  int unsigned err_total = 0;
  int unsigned total_checks = 0;
  always #5 core_clk_in = ~core_clk_in;
  // short watchdog keeps the run small
  sfm_controller #(.WDOG_CYC(50)) dut (
    .core_clk_in, .nrst_in, .wake_reset_in, .failsafe_select_input_in, .vdd_fail_in,
    .vdd_fail_en_in, .spi_word_valid_in, .watchdog_refresh_bit_in, .watchdog_input_bit_in,
    .spi_read_in, .direct_in, .direct_dis_in, .on_bit_in, .pwm_en_in, .pwm_internal_in,
    .pwm_duty_in, .overtemp_in, .overcurrent_in, .severe_short_in, .short_supply_off_in,
    .open_load_off_in, .open_load_on_in, .overvoltage_in, .undervoltage_in, .retry_in,
    .overvoltage_protect_disable_in, .small_lamp_profile_bit_in, .discharge_lamp_bit_in,
    .inrush_slope_field_in, .inrush_step_skip_bit_in, .cool_emulation_enable_in,
    .cool_slope_field_in, .steady_limit_select_in, .hs_out, .oc_level_out(),
    .fault_status_pin_n_out, .normal_mode_flag_out, .full_function_out, .config_default_out,
    .overtemp_flags_out, .overcurrent_flags_out, .severe_short_flags_out,
    .short_supply_flags_out, .open_load_off_flags_out, .open_load_on_flags_out,
    .overvoltage_flag_out, .undervoltage_flag_out
  );
  sfm_host_model host (
    .core_clk_in, .refresh_en_in(refresh_en), .spi_word_valid_out(spi_word_valid_in),
    .watchdog_refresh_bit_out(watchdog_refresh_bit_in),
    .watchdog_input_bit_out(watchdog_input_bit_in)
  );
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t %s: saw %h want %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk_in);
  endtask : cyc
  task automatic pulse_read;
    spi_read_in = 1'b1;
    cyc(1);
    spi_read_in = 1'b0;
  endtask : pulse_read
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  task automatic t_startup;
    int n = 1;
    wake_reset_in = 1'b1; // pwm stays off, so no input zero clock is owed
    cyc(1);
    check(16'(normal_mode_flag_out & undervoltage_flag_out), 16'h1, "wake");
    while (full_function_out !== 1'b1 && n < 6000) begin
      cyc(1);
      n++;
    end
    check(16'(n), 16'(STARTUP_CYC + 2), "start length");
    pulse_read;
    check(16'(undervoltage_flag_out), 16'h0, "uv read");
  endtask : t_startup
  task automatic t_overtemp;
    on_bit_in = 4'h1;
    cyc(1);
    overtemp_in = 4'h1;
    cyc(2);
    check(16'({hs_out, fault_status_pin_n_out}), 16'h0, "ot latch");
    overtemp_in = 4'h0;
    cyc(2);
    check(16'(fault_status_pin_n_out), 16'h0, "ot pin held");
    on_bit_in = 4'h0;
    cyc(2);
    on_bit_in = 4'h1;
    cyc(2);
    check(16'({hs_out, fault_status_pin_n_out}), 16'h3, "ot toggle");
    overtemp_in = 4'h2;
    cyc(2);
    check(16'(fault_status_pin_n_out), 16'h0, "ot while off");
    overtemp_in = 4'h0;
    cyc(2);
    check(16'({overtemp_flags_out, fault_status_pin_n_out}), 16'h7, "ot off");
    pulse_read;
    check(16'(overtemp_flags_out), 16'h0, "ot read");
  endtask : t_overtemp
  task automatic t_current;
    on_bit_in = 4'h2;
    cyc(1);
    severe_short_in = 4'h2;
    cyc(2);
    severe_short_in = 4'h0;
    retry_in = 4'h2;
    cyc(1);
    retry_in = 4'h0;
    cyc(2);
    check(16'({hs_out, severe_short_flags_out}), 16'h2, "short no retry");
    on_bit_in = 4'h0;
    cyc(2);
    on_bit_in = 4'h2;
    cyc(2);
    overcurrent_in = 4'h2;
    cyc(2);
    check(16'({hs_out, fault_status_pin_n_out}), 16'h0, "oc latch");
    overcurrent_in = 4'h0;
    retry_in = 4'h2;
    cyc(1);
    retry_in = 4'h0;
    cyc(2);
    check(16'({hs_out, overcurrent_flags_out}), 16'h22, "oc retry");
    pulse_read;
    check(16'(overcurrent_flags_out | severe_short_flags_out), 16'h0, "read");
  endtask : t_current
  task automatic t_pin_faults;
    on_bit_in = 4'h4;
    open_load_on_in = 4'h4;
    cyc(2);
    check(16'({hs_out, fault_status_pin_n_out, open_load_on_flags_out}), 16'h94, "olon");
    {open_load_on_in, open_load_off_in} = 8'h08;
    cyc(2);
    check(16'({fault_status_pin_n_out, open_load_off_flags_out}), 16'h8, "open off");
    {open_load_off_in, short_supply_off_in} = 8'h08;
    cyc(2);
    check(16'({fault_status_pin_n_out, short_supply_flags_out}), 16'h8, "short supply");
    short_supply_off_in = 4'h0;
    cyc(2);
    check(16'(fault_status_pin_n_out), 16'h1, "pin recovers");
    overvoltage_in = 1'b1;
    cyc(2);
    check(16'({hs_out, fault_status_pin_n_out, overvoltage_flag_out}), 16'h1, "ov");
    overvoltage_in = 1'b0;
    cyc(2);
    check(16'(hs_out), 16'h4, "ov gone");
    {overvoltage_protect_disable_in, overvoltage_in} = 2'h3;
    pulse_read;
    cyc(1);
    check(16'({hs_out, overvoltage_flag_out}), 16'h9, "ov warning");
    {overvoltage_protect_disable_in, overvoltage_in} = 2'h0;
    pulse_read;
    check(16'(overvoltage_flag_out), 16'h0, "ov read");
    {on_bit_in, undervoltage_in} = 5'h01;
    cyc(2);
    check(16'(fault_status_pin_n_out), 16'h0, "uv pin");
    undervoltage_in = 1'b0;
    cyc(2);
    check(16'(fault_status_pin_n_out), 16'h1, "uv gone");
    pulse_read;
  endtask : t_pin_faults
  task automatic t_failsafe;
    int n = 0;
    refresh_en = 1'b0;
    while (normal_mode_flag_out !== 1'b0 && n < 200) begin
      cyc(1);
      n++;
    end
    check(16'(config_default_out), 16'h1, "fs entry");
    {small_lamp_profile_bit_in, discharge_lamp_bit_in, inrush_slope_field_in} = '1;
    {inrush_step_skip_bit_in, cool_emulation_enable_in, cool_slope_field_in} = '1;
    {steady_limit_select_in, pwm_en_in, pwm_internal_in, pwm_duty_in, direct_dis_in} = '1;
    direct_in = 4'h9;
    cyc(2);
    check(16'(hs_out), 16'h9, "fs follows");
    {small_lamp_profile_bit_in, discharge_lamp_bit_in, inrush_slope_field_in} = '0;
    {inrush_step_skip_bit_in, cool_emulation_enable_in, cool_slope_field_in} = '0;
    {steady_limit_select_in, pwm_en_in, pwm_internal_in, pwm_duty_in, direct_dis_in} = '0;
    {direct_in, failsafe_select_input_in} = 5'h00;
    cyc(2);
    check(16'(normal_mode_flag_out), 16'h1, "select low");
    cyc(120);
    check(16'(normal_mode_flag_out), 16'h1, "no watchdog");
    {failsafe_select_input_in, refresh_en, vdd_fail_en_in, vdd_fail_in} = 4'hf;
    cyc(2);
    check(16'(normal_mode_flag_out), 16'h0, "supply fail");
    host.send_exit();
    cyc(3);
    vdd_fail_in = 1'b0;
    cyc(2);
    check(16'(normal_mode_flag_out), 16'h0, "exit refused");
    host.send_exit();
    cyc(3);
    check(16'(normal_mode_flag_out), 16'h1, "exit word");
  endtask : t_failsafe
  initial begin
    {nrst_in, wake_reset_in, vdd_fail_in, vdd_fail_en_in, spi_read_in, pwm_en_in} = '0;
    {pwm_internal_in, overvoltage_in, undervoltage_in, overvoltage_protect_disable_in} = '0;
    {inrush_step_skip_bit_in, cool_emulation_enable_in, inrush_slope_field_in} = '0;
    {cool_slope_field_in, steady_limit_select_in, direct_in, direct_dis_in, on_bit_in} = '0;
    {pwm_duty_in, overtemp_in, overcurrent_in, severe_short_in, short_supply_off_in} = '0;
    {open_load_off_in, open_load_on_in, retry_in, small_lamp_profile_bit_in} = '0;
    {discharge_lamp_bit_in, failsafe_select_input_in, refresh_en} = 6'h03;
    cyc(2);
    nrst_in = 1'b1;
    t_startup();
    t_overtemp();
    t_current();
    t_pin_faults();
    t_failsafe();
    end_of_test();
  end
  initial begin
    repeat (100000) @(posedge core_clk_in);
    err_total++;
    end_of_test();
  end
endmodule : tb_switch_fault_mode_controller
